// ==== hdl/fprs_clk_gate.sv ====
// fprs_clk_gate: latch-based clock gate for the floating-point unit clock
// assumes enable changes only while the clock is high or stable
`default_nettype none
module fprs_clk_gate
(
    input  wire logic clk_i,
    input  wire logic en_i,
    output logic      gclk_o
);
    logic en_latch;

    // latch is transparent while the clock is low, so no glitch reaches gclk_o
    always_latch
    begin
        if (!clk_i)
        begin
            en_latch = en_i;
        end
    end

    assign gclk_o = clk_i & en_latch;
endmodule
`default_nettype wire

// ==== hdl/fprs_top.sv ====
// fprs_top: floating-point register bank, fflags/frm storage, FS tracking and fpu clock gate
// assumes the pipeline presents one request per cycle, writes take effect at the next edge
`default_nettype none
module fprs_top
#(
    parameter bit ZFINX = 1'b0
)
(
    input  wire logic               mclk_i,
    input  wire logic               rst_i,
    input  wire logic               core_sleep_i,
    input  wire fprs_pkg::fprs_req_t req_i,
    input  wire logic               fs_we_i,
    input  wire fprs_pkg::fprs_fs_t fs_wdata_i,
    input  wire logic [31:0]        xrf_rs1_i,
    input  wire logic [31:0]        xrf_rs2_i,
    input  wire logic [31:0]        xrf_rs3_i,
    output fprs_pkg::fprs_rsp_t     rsp_o,
    output fprs_pkg::fprs_fs_t      fs_o,
    output logic                    sd_o,
    output logic                    xrf_we_o,
    output logic                    fpu_clk_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // status, access check
    fprs_pkg::fprs_fs_t fs_reg;
    fprs_pkg::fprs_fs_t fs_next;
    logic               access;
    logic               illegal;
    logic               state_wr;
    logic               go;

    function automatic logic [31:0] fcsr_pack(input logic [2:0] frm, input logic [4:0] flg);
        fcsr_pack = {24'h000000, frm, flg};
    endfunction

    assign access   = req_i.valid && (req_i.fp_instr || req_i.csr_sel != fprs_pkg::FPRS_CSR_NONE);
    assign illegal  = access && (fs_reg == fprs_pkg::FPRS_FS_OFF);
    assign go       = access && !illegal;
    assign state_wr = go && (req_i.rd_we || req_i.flags_acc || req_i.csr_we);

    always_comb
    begin
        fs_next = fs_reg;
        if (fs_we_i)
        begin
            fs_next = fs_wdata_i;
        end
        // hardware dirty mark wins over a same-cycle software write while fs_reg is initial or clean
        if (state_wr && (fs_reg == fprs_pkg::FPRS_FS_INITIAL || fs_reg == fprs_pkg::FPRS_FS_CLEAN))
        begin
            fs_next = fprs_pkg::FPRS_FS_DIRTY;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            fs_reg <= fprs_pkg::FPRS_FS_OFF;
        end
        else
        begin
            fs_reg <= fs_next;
        end
    end

    assign fs_o = fs_reg;
    assign sd_o = (fs_reg == fprs_pkg::FPRS_FS_DIRTY);

    ////////////////////////////////////////////////////////////////////////////////
    // fflags and frm, the fcsr view is built from both
    logic [4:0] flags_reg;
    logic [4:0] flags_next;
    logic [2:0] frm_reg;
    logic [2:0] frm_next;
    logic       csr_wr;

    assign csr_wr = go && req_i.csr_we;

    always_comb
    begin
        flags_next = flags_reg;
        frm_next   = frm_reg;
        if (csr_wr)
        begin
            unique case (req_i.csr_sel)
                fprs_pkg::FPRS_CSR_FFLAGS: flags_next = req_i.csr_wdata[4:0];
                fprs_pkg::FPRS_CSR_FRM:    frm_next   = req_i.csr_wdata[2:0];
                fprs_pkg::FPRS_CSR_FCSR:
                begin
                    flags_next = req_i.csr_wdata[4:0];
                    frm_next   = req_i.csr_wdata[7:5];
                end
                fprs_pkg::FPRS_CSR_NONE: ;
            endcase
        end
        // accrued flags are or-ed in after a csr write, so a raise is never lost
        if (go && req_i.flags_acc)
        begin
            flags_next = flags_next | req_i.flags_in;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            flags_reg <= fprs_pkg::FLAGS_RST;
            frm_reg   <= fprs_pkg::FRM_RST;
        end
        else
        begin
            flags_reg <= flags_next;
            frm_reg   <= frm_next;
        end
    end

    logic [31:0] csr_rd;
    always_comb
    begin
        csr_rd = 32'h00000000;
        unique case (req_i.csr_sel)
            fprs_pkg::FPRS_CSR_FFLAGS: csr_rd = {27'h0, flags_reg};
            fprs_pkg::FPRS_CSR_FRM:    csr_rd = {29'h0, frm_reg};
            fprs_pkg::FPRS_CSR_FCSR:   csr_rd = fcsr_pack(frm_reg, flags_reg);
            fprs_pkg::FPRS_CSR_NONE:   csr_rd = 32'h00000000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register bank or shared integer file
    logic [31:0] rs1_d;
    logic [31:0] rs2_d;
    logic [31:0] rs3_d;

    generate
        if (ZFINX)
        begin : g_shared
            assign rs1_d    = xrf_rs1_i;
            assign rs2_d    = xrf_rs2_i;
            assign rs3_d    = xrf_rs3_i;
            assign xrf_we_o = go && req_i.rd_we;
        end
        else
        begin : g_bank
            logic [31:0] bank_reg  [fprs_pkg::NUM_FREGS];
            logic [31:0] bank_next [fprs_pkg::NUM_FREGS];
            always_comb
            begin
                bank_next = bank_reg;
                if (go && req_i.rd_we)
                begin
                    bank_next[req_i.rd] = req_i.rd_data;
                end
            end
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                begin
                    for (int i = 0; i < fprs_pkg::NUM_FREGS; i++)
                    begin
                        bank_reg[i] <= 32'h00000000;
                    end
                end
                else
                begin
                    bank_reg <= bank_next;
                end
            end
            assign rs1_d    = bank_reg[req_i.rs1];
            assign rs2_d    = bank_reg[req_i.rs2];
            assign rs3_d    = bank_reg[req_i.rs3];
            assign xrf_we_o = 1'b0;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // response: data from the bank and csr flip-flops, or from the xrf inputs in the shared build, illegal as a handshake term
    always_comb
    begin
        rsp_o           = '0;
        rsp_o.rs1_data  = go ? rs1_d : 32'h00000000;
        rsp_o.rs2_data  = go ? rs2_d : 32'h00000000;
        rsp_o.rs3_data  = go ? rs3_d : 32'h00000000;
        rsp_o.csr_rdata = go ? csr_rd : 32'h00000000;
        rsp_o.illegal   = illegal;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // fpu clock gate
    fprs_clk_gate u_gate
    (
        .clk_i  (mclk_i),
        .en_i   (~core_sleep_i),
        .gclk_o (fpu_clk_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // assertions
    a_off_illegal: assert property (@(posedge mclk_i) disable iff (rst_i)
        (access && fs_o == fprs_pkg::FPRS_FS_OFF)
        |-> (rsp_o.illegal && rsp_o.rs1_data == 32'h00000000 && rsp_o.csr_rdata == 32'h00000000))
        else $error("fp access with FS off not flagged");
    a_sd_dirty: assert property (@(posedge mclk_i) disable iff (rst_i)
        sd_o == (fs_o == fprs_pkg::FPRS_FS_DIRTY))
        else $error("SD does not track FS dirty");
    a_fs_dirty_set: assert property (@(posedge mclk_i) disable iff (rst_i)
        (state_wr && !(fs_we_i && fs_o == fprs_pkg::FPRS_FS_DIRTY))
        |=> fs_o == fprs_pkg::FPRS_FS_DIRTY)
        else $error("state write did not set FS dirty");
    a_off_no_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        (fs_o == fprs_pkg::FPRS_FS_OFF && !fs_we_i) |=> ($stable(flags_reg) && $stable(frm_reg)))
        else $error("fp csr changed while FS off");
    a_fcsr_alias: assert property (@(posedge mclk_i) disable iff (rst_i)
        (csr_wr && req_i.csr_sel == fprs_pkg::FPRS_CSR_FCSR && !req_i.flags_acc)
        |=> (frm_reg == $past(req_i.csr_wdata[7:5]) && flags_reg == $past(req_i.csr_wdata[4:0])))
        else $error("fcsr write not seen in frm and fflags");
    a_frm_write: assert property (@(posedge mclk_i) disable iff (rst_i)
        (csr_wr && req_i.csr_sel == fprs_pkg::FPRS_CSR_FRM) |=> frm_reg == $past(req_i.csr_wdata[2:0]))
        else $error("frm write lost");
    a_flags_sticky: assert property (@(posedge mclk_i) disable iff (rst_i)
        (go && req_i.flags_acc) |=> ((flags_reg & $past(req_i.flags_in)) == $past(req_i.flags_in)))
        else $error("accrued flag lost");
    // sampled at the falling edge, where the gated clock shows the latched enable
    a_gate_sleep: assert property (@(negedge mclk_i) disable iff (rst_i)
        core_sleep_i [*2] |-> !fpu_clk_o)
        else $error("fpu clock runs during sleep");
    a_gate_awake: assert property (@(negedge mclk_i) disable iff (rst_i)
        (!core_sleep_i) [*2] |-> fpu_clk_o)
        else $error("fpu clock stopped while awake");
    c_illegal: cover property (@(posedge mclk_i) disable iff (rst_i) rsp_o.illegal);
    c_dirty: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(sd_o));
    c_fcsr_wr: cover property (@(posedge mclk_i) disable iff (rst_i)
        csr_wr && req_i.csr_sel == fprs_pkg::FPRS_CSR_FCSR);
    c_sleep: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(core_sleep_i));
endmodule
`default_nettype wire

// ==== pkg/fprs_pkg.sv ====
// fprs_pkg: constants and carriers for the floating-point register state block
// assumes a single core clock and synchronous active-high reset
`default_nettype none
package fprs_pkg;
    localparam int unsigned NUM_FREGS    = 32;
    localparam int unsigned FREG_AW      = 5;
    localparam int unsigned XLEN         = 32;
    localparam int unsigned FLAGS_W      = 5;
    localparam int unsigned FRM_W        = 3;
    localparam int unsigned FCSR_FRM_LSB = 5;
    localparam logic [4:0]  FLAGS_RST    = 5'h00;
    localparam logic [2:0]  FRM_RST      = 3'h0;

    typedef enum logic [1:0]
    {
        FPRS_FS_OFF     = 2'b00,
        FPRS_FS_INITIAL = 2'b01,
        FPRS_FS_CLEAN   = 2'b10,
        FPRS_FS_DIRTY   = 2'b11
    } fprs_fs_t;

    typedef enum logic [1:0]
    {
        FPRS_CSR_FFLAGS = 2'b00,
        FPRS_CSR_FRM    = 2'b01,
        FPRS_CSR_FCSR   = 2'b10,
        FPRS_CSR_NONE   = 2'b11
    } fprs_csr_sel_t;

    // one floating-point state request from the pipeline
    typedef struct packed
    {
        logic          valid;
        logic          fp_instr;
        logic [4:0]    rs1;
        logic [4:0]    rs2;
        logic [4:0]    rs3;
        logic          rd_we;
        logic [4:0]    rd;
        logic [31:0]   rd_data;
        logic          flags_acc;
        logic [4:0]    flags_in;
        fprs_csr_sel_t csr_sel;
        logic          csr_we;
        logic [31:0]   csr_wdata;
    } fprs_req_t;

    typedef struct packed
    {
        logic [31:0] rs1_data;
        logic [31:0] rs2_data;
        logic [31:0] rs3_data;
        logic [31:0] csr_rdata;
        logic        illegal;
    } fprs_rsp_t;
endpackage
`default_nettype wire

// ==== verification/fprs_core_model.sv ====
// fprs_core_model: pipeline and software stand-in for the fp state block
// assumes its tasks are called from one bench process
`default_nettype none
module fprs_core_model
(
    input  wire logic                mclk_i,
    input  wire fprs_pkg::fprs_rsp_t rsp_i,
    input  wire logic                sd_i,
    input  wire fprs_pkg::fprs_fs_t  fs_i,
    input  wire logic                xrf_we_i,
    output fprs_pkg::fprs_req_t      req_o,
    output logic                     fs_we_o,
    output fprs_pkg::fprs_fs_t       fs_wd_o,
    output logic [31:0]              xrs1_o,
    output logic [31:0]              xrs2_o,
    output logic [31:0]              xrs3_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0]         xrf [32];
    logic [31:0]         save [32];
    fprs_pkg::fprs_rsp_t last;
    initial
    begin
        req_o = '0;
        fs_we_o = 1'b0;
        fs_wd_o = fprs_pkg::FPRS_FS_OFF;
        for (int i = 0; i < 32; i++) xrf[i] = 32'(i) * 32'h01010101;
    end
    assign xrs1_o = xrf[req_o.rs1];
    assign xrs2_o = xrf[req_o.rs2];
    assign xrs3_o = xrf[req_o.rs3];
    // integer file takes fp results in the shared build
    always @(posedge mclk_i) if (xrf_we_i) xrf[req_o.rd] <= req_o.rd_data;
    function automatic fprs_pkg::fprs_req_t rq(input logic we, input logic [4:0] a,
        input logic [31:0] d, input fprs_pkg::fprs_csr_sel_t s, input logic cw);
        rq = '0;
        rq.valid = 1'b1;
        rq.fp_instr = (s == fprs_pkg::FPRS_CSR_NONE);
        rq.rs1 = a;
        rq.rs2 = ~a;
        rq.rs3 = a;
        rq.rd_we = we;
        rq.rd = a;
        rq.rd_data = d;
        rq.csr_sel = s;
        rq.csr_we = cw;
        rq.csr_wdata = d;
    endfunction
    // request stands from a falling edge through the next rising edge
    task automatic issue(input fprs_pkg::fprs_req_t r);
        @(negedge mclk_i);
        req_o = r;
        #1 last = rsp_i;
        @(posedge mclk_i);
        #1;
    endtask
    task automatic set_fs(input fprs_pkg::fprs_fs_t v);
        @(negedge mclk_i);
        req_o = '0;
        fs_we_o = 1'b1;
        fs_wd_o = v;
        @(negedge mclk_i);
        fs_we_o = 1'b0;
    endtask
    task automatic ctx_save;
        if (sd_i)
        begin
            for (int i = 0; i < 32; i++)
            begin
                issue(rq(1'b0, 5'(i), 32'h0, fprs_pkg::FPRS_CSR_NONE, 1'b0));
                save[i] = last.rs1_data;
            end
            set_fs(fprs_pkg::FPRS_FS_CLEAN);
        end
    endtask
    task automatic ctx_restore;
        if (fs_i == fprs_pkg::FPRS_FS_CLEAN)
            for (int i = 0; i < 32; i++)
                issue(rq(1'b1, 5'(i), save[i], fprs_pkg::FPRS_CSR_NONE, 1'b0));
    endtask
endmodule
`default_nettype wire

// ==== verification/fprs_top_bench.sv ====
// fprs_top_bench: self-checking bench for the fp register state block
// assumes the core model drives every request; two builds share it
`default_nettype none
module fprs_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                mclk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                sleep = 1'b0;
    fprs_pkg::fprs_req_t req;
    fprs_pkg::fprs_rsp_t rsp;
    fprs_pkg::fprs_rsp_t rsp2;
    fprs_pkg::fprs_fs_t  fs;
    fprs_pkg::fprs_fs_t  fs_wd;
    logic                fs_we;
    logic                sd;
    logic                gclk;
    logic                xwe;
    logic [31:0]         x1;
    logic [31:0]         x2;
    logic [31:0]         x3;
    fprs_pkg::fprs_fs_t  fs2;
    logic                sd2;
    logic                gclk2;
    logic                xwe0;
    int                  mismatches = 0;
    int                  checks_done = 0;
    always #20 mclk_i = ~mclk_i;
    fprs_top uut (.mclk_i(mclk_i), .rst_i(rst_i), .core_sleep_i(sleep), .req_i(req),
        .fs_we_i(fs_we), .fs_wdata_i(fs_wd), .xrf_rs1_i(x1), .xrf_rs2_i(x2), .xrf_rs3_i(x3),
        .rsp_o(rsp), .fs_o(fs), .sd_o(sd), .xrf_we_o(xwe0), .fpu_clk_o(gclk));
    fprs_top #(.ZFINX(1'b1)) uut2 (.mclk_i(mclk_i), .rst_i(rst_i), .core_sleep_i(sleep),
        .req_i(req), .fs_we_i(fs_we), .fs_wdata_i(fs_wd), .xrf_rs1_i(x1), .xrf_rs2_i(x2),
        .xrf_rs3_i(x3), .rsp_o(rsp2), .fs_o(fs2), .sd_o(sd2), .xrf_we_o(xwe),
        .fpu_clk_o(gclk2));
    fprs_core_model cm (.mclk_i(mclk_i), .rsp_i(rsp), .sd_i(sd), .fs_i(fs), .xrf_we_i(xwe),
        .req_o(req), .fs_we_o(fs_we), .fs_wd_o(fs_wd), .xrs1_o(x1), .xrs2_o(x2), .xrs3_o(x3));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic t_off;
        logic [31:0] fcsr_rst;
        fcsr_rst = {24'h000000, fprs_pkg::FRM_RST, fprs_pkg::FLAGS_RST};
        cmp(32'(fs), 32'(fprs_pkg::FPRS_FS_OFF), "fs at reset");
        cm.issue(cm.rq(1'b1, 5'h03, 32'h5a5a0003, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(32'(cm.last.illegal), 32'h1, "reg write while off");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FCSR, 1'b0));
        cmp(32'(cm.last.illegal), 32'h1, "csr read while off");
        cm.set_fs(fprs_pkg::FPRS_FS_INITIAL);
        cm.issue(cm.rq(1'b0, 5'h03, 32'h0, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(32'(cm.last.illegal), 32'h0, "read when initial");
        cmp(cm.last.rs1_data, 32'h0, "refused write left f3");
        cmp(32'(sd), 32'h0, "sd when initial");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FCSR, 1'b0));
        cmp(cm.last.csr_rdata, fcsr_rst, "fcsr at reset");
        $display("test off done");
    endtask
    task automatic t_bank;
        cm.issue(cm.rq(1'b1, 5'h00, 32'hc0de0000, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(32'(fs), 32'(fprs_pkg::FPRS_FS_DIRTY), "fs after write");
        cmp(32'(sd), 32'h1, "sd when dirty");
        cmp(32'(fs2), 32'(fprs_pkg::FPRS_FS_DIRTY), "shared build fs");
        cmp(32'(sd2), 32'h1, "shared build sd");
        cm.issue(cm.rq(1'b1, 5'h1f, 32'hc0de001f, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(32'(xwe0), 32'h0, "own bank keeps int file idle");
        cmp(32'(xwe), 32'h1, "shared build writes int file");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(cm.last.rs1_data, 32'hc0de0000, "f0");
        cmp(cm.last.rs2_data, 32'hc0de001f, "f31");
        cmp(cm.last.rs3_data, 32'hc0de0000, "f0 via third port");
        cmp(cm.xrf[0], 32'hc0de0000, "shared build int file");
        cmp(rsp2.rs2_data, 32'hc0de001f, "shared build read");
        $display("test bank done");
    endtask
    task automatic t_csr;
        fprs_pkg::fprs_req_t r;
        cm.set_fs(fprs_pkg::FPRS_FS_CLEAN);
        cmp(32'(sd), 32'h0, "sd when clean");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h000000b5, fprs_pkg::FPRS_CSR_FCSR, 1'b1));
        cmp(32'(fs), 32'(fprs_pkg::FPRS_FS_DIRTY), "fs after csr write");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FFLAGS, 1'b0));
        cmp(cm.last.csr_rdata, 32'h15, "fflags via fcsr");
        cm.issue(cm.rq(1'b0, 5'h00, 32'h3, fprs_pkg::FPRS_CSR_FRM, 1'b1));
        cmp(cm.last.csr_rdata, 32'h5, "frm via fcsr");
        r = cm.rq(1'b0, 5'h00, 32'h02, fprs_pkg::FPRS_CSR_FFLAGS, 1'b1);
        r.flags_acc = 1'b1;
        r.flags_in = 5'h08;
        cm.issue(r);
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FCSR, 1'b0));
        cmp(cm.last.csr_rdata, 32'h6a, "fcsr after field writes");
        $display("test csr done");
    endtask
    task automatic t_ctx;
        cm.ctx_save();
        cmp(32'(fs), 32'(fprs_pkg::FPRS_FS_CLEAN), "fs after save");
        cm.issue(cm.rq(1'b1, 5'h1f, 32'h0, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cm.set_fs(fprs_pkg::FPRS_FS_CLEAN);
        cm.ctx_restore();
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_NONE, 1'b0));
        cmp(cm.last.rs2_data, 32'hc0de001f, "f31 restored");
        $display("test ctx done");
    endtask
    task automatic t_refuse;
        cm.set_fs(fprs_pkg::FPRS_FS_OFF);
        cm.issue(cm.rq(1'b1, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FCSR, 1'b1));
        cmp(32'(cm.last.illegal), 32'h1, "fcsr write while off");
        cmp(cm.last.rs1_data, 32'h0, "f0 hidden while off");
        cmp(cm.last.csr_rdata, 32'h0, "fcsr hidden while off");
        cmp(32'(fs), 32'(fprs_pkg::FPRS_FS_OFF), "fs stays off");
        cm.set_fs(fprs_pkg::FPRS_FS_CLEAN);
        cm.issue(cm.rq(1'b0, 5'h00, 32'h0, fprs_pkg::FPRS_CSR_FCSR, 1'b0));
        cmp(cm.last.csr_rdata, 32'h6a, "fcsr kept through off");
        cmp(cm.last.rs1_data, 32'hc0de0000, "f0 kept through off");
        cmp(32'(sd), 32'h0, "sd clean after read");
        $display("test refuse done");
    endtask
    task automatic t_sleep;
        @(negedge mclk_i);
        sleep = 1'b1;
        repeat (3) @(posedge mclk_i);
        #1 cmp(32'(gclk), 32'h0, "fpu clock while asleep");
        cmp(32'(gclk2), 32'h0, "shared build clock asleep");
        @(negedge mclk_i);
        sleep = 1'b0;
        @(posedge mclk_i);
        #1 cmp(32'(gclk), 32'h1, "fpu clock awake");
        $display("test sleep done");
    endtask
    initial
    begin
        repeat (10) @(negedge mclk_i);
        rst_i = 1'b0;
        t_off();
        t_bank();
        t_csr();
        t_ctx();
        t_refuse();
        t_sleep();
        end_of_test();
    end
endmodule
`default_nettype wire
